/* File: design/hvm_monitor_top.sv */
// High-voltage monitor status register behind the indirect command interface
//
// Overview of operation
// [R1] Eight-bit read-only live monitor register
// [R2] Reached only via indirect command, data register
// [R3] No memory-mapped path reaches the register
// [R4] Bit 7 follows wake pin in input mode
// [R5] Bit 6 shows thermal shutdown occurred
// [R6] Bit 5 follows serial-test pin in input mode
// [R7] Bit 4 shows ADC input buffer enabled
// [R8] Bit 3 valid only when flag enabled
// [R9] Bit 3 one if supply stayed above threshold
// [R10] Retention flag cleared only by re-enabling it
// [R11] Bit 2 sets on line driver short
// [R12] Line short cleared by driver re-enable write
// [R13] Bit 1 sets on serial-test driver short
// [R14] Serial-test short cleared by re-enable write
// [R15] Bit 0 sets on wake driver short
// [R16] Re-enable pulse restores pins, self-clears
// [R17] Busy stands ten microseconds per transfer
// [R18] Reads never disturb monitor bits
`timescale 1ns/1ps
module hvm_monitor_top (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic cmd_start,
	input wire logic [hvm_pkg::SEL_W-1:0] cmd_sel,
	input wire logic wake_pin_level,
	input wire logic serial_test_pin_level,
	input wire logic pin_input_mode,
	input wire logic thermal_event,
	input wire logic adc_buffer_on,
	input wire logic supply_stayed_ok,
	input wire logic low_voltage_flag_en,
	input wire logic low_voltage_flag_en_wr,
	input wire logic driver_reenable_wr,
	input wire logic line_short_event,
	input wire logic serial_test_short_event,
	input wire logic wake_short_event,
	output logic hv_busy_ff,
	output logic hv_error_ff,
	output logic [hvm_pkg::MON_W-1:0] hv_data_register_ff,
	output logic [hvm_pkg::MON_W-1:0] hv_monitor_status_ff,
	output logic driver_reenable_ff
);

	// Two states; the counter alone times the busy window
	typedef enum logic {HVM_IDLE, HVM_BUSY} hvm_state_t;

	hvm_state_t state_ff;
	// Counter width must cover the busy window at this clock
	logic [hvm_pkg::BUSY_CNT_W-1:0] busy_cnt_ff;
	logic [hvm_pkg::SEL_W-1:0] sel_ff;
	logic over_temp_ff;
	logic line_short_ff;
	logic serial_test_short_ff;
	logic wake_short_ff;
	logic low_voltage_ff;
	logic strap_taken_ff;
	// Image ahead of its flop; the data snapshot reads it too
	logic [hvm_pkg::MON_W-1:0] nxt_monitor;

	////////////////////////////////////////////////////////////////////////
	// Sticky event flags; a new event wins over a same-cycle clear
	// Thermal flag cleared by the re-enable write that restores the pins
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			over_temp_ff <= 1'b0;
		end else if (thermal_event) begin
			over_temp_ff <= 1'b1; // see [R5]
		end else if (driver_reenable_wr) begin
			over_temp_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			line_short_ff <= 1'b0;
		end else if (line_short_event) begin
			line_short_ff <= 1'b1; // see [R11]
		end else if (driver_reenable_wr) begin
			line_short_ff <= 1'b0; // see [R12]
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			serial_test_short_ff <= 1'b0;
		end else if (serial_test_short_event) begin
			serial_test_short_ff <= 1'b1; // see [R13]
		end else if (driver_reenable_wr) begin
			serial_test_short_ff <= 1'b0; // see [R14]
		end
	end

	// Wake short cleared by the same re-enable write, else it would stick forever
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wake_short_ff <= 1'b0;
		end else if (wake_short_event) begin
			wake_short_ff <= 1'b1; // see [R15]
		end else if (driver_reenable_wr) begin
			wake_short_ff <= 1'b0;
		end
	end

	// Pins themselves are restored outside this block, by this strobe
	// Re-enable strobe lasts one cycle and returns to zero by itself
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			driver_reenable_ff <= 1'b0;
		end else begin
			driver_reenable_ff <= driver_reenable_wr; // see [R16]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Supply strap caught on the first clock after reset release, not in reset
	// Keeps the reset branch constant-only; strap assumed steady by then
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			strap_taken_ff <= 1'b0;
			low_voltage_ff <= 1'b0;
		end else if (!strap_taken_ff) begin
			strap_taken_ff <= 1'b1;
			low_voltage_ff <= supply_stayed_ok; // see [R9]
		end else if (low_voltage_flag_en_wr && low_voltage_flag_en) begin
			low_voltage_ff <= 1'b0; // see [R10]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Live monitor image
	always_comb begin
		nxt_monitor = hvm_pkg::MON_RESET;
		nxt_monitor[hvm_pkg::BIT_WAKE_PIN] = pin_input_mode & wake_pin_level; // see [R4]
		nxt_monitor[hvm_pkg::BIT_OVER_TEMP] = over_temp_ff; // see [R5]
		nxt_monitor[hvm_pkg::BIT_SERIAL_TEST_PIN] = pin_input_mode
			& serial_test_pin_level; // see [R6]
		nxt_monitor[hvm_pkg::BIT_ADC_BUFFER] = adc_buffer_on; // see [R7]
		nxt_monitor[hvm_pkg::BIT_LOW_VOLTAGE] = low_voltage_flag_en & low_voltage_ff; // see [R8]
		nxt_monitor[hvm_pkg::BIT_LINE_SHORT] = line_short_ff;
		nxt_monitor[hvm_pkg::BIT_SERIAL_TEST_SHORT] = serial_test_short_ff;
		nxt_monitor[hvm_pkg::BIT_WAKE_SHORT] = wake_short_ff;
	end

	// Image depends on no read path, so a read cannot disturb it
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			hv_monitor_status_ff <= hvm_pkg::MON_RESET;
		end else begin
			hv_monitor_status_ff <= nxt_monitor; // see [R1] see [R18]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Last counting cycle of a transfer; the sequencer and the result share it
	function automatic logic xfer_done(input hvm_state_t st,
		input logic [hvm_pkg::BUSY_CNT_W-1:0] cnt);
		return (st == HVM_BUSY) && (cnt == hvm_pkg::BUSY_LAST);
	endfunction : xfer_done

	////////////////////////////////////////////////////////////////////////
	// Indirect command interface; no memory-mapped port exists at all
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= HVM_IDLE;
			busy_cnt_ff <= '0;
			hv_busy_ff <= 1'b0;
		end else begin
			case (state_ff)
				HVM_IDLE: begin
					if (cmd_start) begin
						state_ff <= HVM_BUSY; // see [R2] see [R3]
						busy_cnt_ff <= '0;
						hv_busy_ff <= 1'b1; // see [R17]
					end
				end
				HVM_BUSY: begin
					// Starts while busy are dropped; the serial link holds one transfer
					if (xfer_done(state_ff, busy_cnt_ff)) begin
						state_ff <= HVM_IDLE;
						hv_busy_ff <= 1'b0; // see [R17]
					end else begin
						busy_cnt_ff <= busy_cnt_ff + 1'b1;
					end
				end
				default: begin
					state_ff <= HVM_IDLE;
					hv_busy_ff <= 1'b0;
				end
			endcase
		end
	end

	// Target taken with the start, so a select change while busy is ignored
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sel_ff <= '0;
		end else if (state_ff == HVM_IDLE && cmd_start) begin
			sel_ff <= cmd_sel; // see [R2]
		end
	end

	// Snapshot at busy fall, not at start, so software reads the newest image
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			hv_data_register_ff <= hvm_pkg::MON_RESET;
		end else if (xfer_done(state_ff, busy_cnt_ff) && sel_ff == hvm_pkg::SEL_MONITOR) begin
			hv_data_register_ff <= nxt_monitor; // see [R2]
		end
	end

	// Unknown targets raise the error and leave the data register unchanged
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			hv_error_ff <= 1'b0;
		end else if (xfer_done(state_ff, busy_cnt_ff)) begin
			hv_error_ff <= (sel_ff != hvm_pkg::SEL_MONITOR); // see [R2]
		end
	end

endmodule : hvm_monitor_top

/* File: design/hvm_pkg.sv */
// Constants for the high-voltage monitor status block
package hvm_pkg;
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned BUSY_TIME_NS = 10000;
	localparam int unsigned BUSY_CYCLES = (BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned BUSY_CNT_W = 8;
	localparam logic [BUSY_CNT_W-1:0] BUSY_LAST = BUSY_CNT_W'(BUSY_CYCLES - 1);

	localparam int unsigned MON_W = 8;
	localparam logic [MON_W-1:0] MON_RESET = 8'h00;
	localparam int unsigned BIT_WAKE_PIN = 7;
	localparam int unsigned BIT_OVER_TEMP = 6;
	localparam int unsigned BIT_SERIAL_TEST_PIN = 5;
	localparam int unsigned BIT_ADC_BUFFER = 4;
	localparam int unsigned BIT_LOW_VOLTAGE = 3;
	localparam int unsigned BIT_LINE_SHORT = 2;
	localparam int unsigned BIT_SERIAL_TEST_SHORT = 1;
	localparam int unsigned BIT_WAKE_SHORT = 0;

	localparam int unsigned SEL_W = 3;
	localparam logic [SEL_W-1:0] SEL_MONITOR = 3'h1;
endpackage : hvm_pkg

/* File: testbench/hvm_monitor_asserts.sv */
// Port checks for the monitor status block
`timescale 1ns/1ps
module hvm_monitor_asserts (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic cmd_start,
	input wire logic [2:0] cmd_sel,
	input wire logic wake_pin_level,
	input wire logic serial_test_pin_level,
	input wire logic pin_input_mode,
	input wire logic thermal_event,
	input wire logic adc_buffer_on,
	input wire logic low_voltage_flag_en,
	input wire logic driver_reenable_wr,
	input wire logic line_short_event,
	input wire logic serial_test_short_event,
	input wire logic wake_short_event,
	input wire logic hv_busy_ff,
	input wire logic hv_error_ff,
	input wire logic [7:0] hv_data_register_ff,
	input wire logic [7:0] hv_monitor_status_ff,
	input wire logic driver_reenable_ff
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	a_busy_len: assert property (cmd_start && !hv_busy_ff |=>
		hv_busy_ff ##199 hv_busy_ff ##1 !hv_busy_ff) else $error("busy length");
	a_sel_error: assert property (cmd_start && !hv_busy_ff && cmd_sel != 3'h1 |->
		##201 hv_error_ff) else $error("no error on bad select");
	a_sel_ok: assert property (cmd_start && !hv_busy_ff && cmd_sel == 3'h1 |->
		##201 !hv_error_ff) else $error("error on monitor select");
	a_data_snap: assert property ($fell(hv_busy_ff) && !hv_error_ff |->
		hv_data_register_ff == hv_monitor_status_ff) else $error("bad data");
	a_data_hold: assert property ($fell(hv_busy_ff) && hv_error_ff |->
		hv_data_register_ff == $past(hv_data_register_ff)) else $error("data changed");
	a_pin_follow: assert property ($past(rst_n) && $past(pin_input_mode) |->
		hv_monitor_status_ff[7] == $past(wake_pin_level) &&
		hv_monitor_status_ff[5] == $past(serial_test_pin_level)) else $error("pin bit");
	a_buf_bit: assert property ($past(rst_n) |->
		hv_monitor_status_ff[4] == $past(adc_buffer_on)) else $error("buffer bit");
	a_lv_gate: assert property (!$past(low_voltage_flag_en) |->
		!hv_monitor_status_ff[3]) else $error("retention bit not gated");
	a_temp_set: assert property (thermal_event |->
		##2 hv_monitor_status_ff[6]) else $error("thermal flag not set");
	a_line_set: assert property (line_short_event |->
		##2 hv_monitor_status_ff[2]) else $error("line short not set");
	a_line_clr: assert property (driver_reenable_wr && !line_short_event |->
		##2 !hv_monitor_status_ff[2]) else $error("line short not cleared");
	a_stest_set: assert property (serial_test_short_event |->
		##2 hv_monitor_status_ff[1]) else $error("serial-test short not set");
	a_stest_clr: assert property (driver_reenable_wr && !serial_test_short_event |->
		##2 !hv_monitor_status_ff[1]) else $error("serial-test short not cleared");
	a_wake_set: assert property (wake_short_event |->
		##2 hv_monitor_status_ff[0]) else $error("wake short not set");
	a_reen_pulse: assert property ($past(rst_n) |->
		driver_reenable_ff == $past(driver_reenable_wr)) else $error("re-enable pulse");
endmodule : hvm_monitor_asserts
bind hvm_monitor_top hvm_monitor_asserts u_chk (
	.clk_sys(clk_sys),
	.rst_n(rst_n),
	.cmd_start(cmd_start),
	.cmd_sel(cmd_sel),
	.wake_pin_level(wake_pin_level),
	.serial_test_pin_level(serial_test_pin_level),
	.pin_input_mode(pin_input_mode),
	.thermal_event(thermal_event),
	.adc_buffer_on(adc_buffer_on),
	.low_voltage_flag_en(low_voltage_flag_en),
	.driver_reenable_wr(driver_reenable_wr),
	.line_short_event(line_short_event),
	.serial_test_short_event(serial_test_short_event),
	.wake_short_event(wake_short_event),
	.hv_busy_ff(hv_busy_ff),
	.hv_error_ff(hv_error_ff),
	.hv_data_register_ff(hv_data_register_ff),
	.hv_monitor_status_ff(hv_monitor_status_ff),
	.driver_reenable_ff(driver_reenable_ff)
);

/* File: testbench/tb.sv */
// Self-checking bench for the monitor status block
`timescale 1ns/1ps
module tb;
	logic clk_sys = 0, rst_n = 0, cmd_start = 0, wake_pin_level = 0, serial_test_pin_level = 0;
	logic pin_input_mode = 0, thermal_event = 0, adc_buffer_on = 0, supply_stayed_ok = 1;
	logic low_voltage_flag_en = 0, low_voltage_flag_en_wr = 0, driver_reenable_wr = 0;
	logic line_short_event = 0, serial_test_short_event = 0, wake_short_event = 0;
	logic [2:0] cmd_sel = 3'h1;
	logic hv_busy_ff, hv_error_ff, driver_reenable_ff;
	logic [7:0] hv_data_register_ff, hv_monitor_status_ff, ms = 8'h08, mk = 8'hFF, pv;
	logic [4:0] ev;
	logic [31:0] lf = 32'h6F4C;
	int mismatches = 0, cmp_count = 0, cyc = 0;
	hvm_monitor_top dut (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.cmd_start(cmd_start),
		.cmd_sel(cmd_sel),
		.wake_pin_level(wake_pin_level),
		.serial_test_pin_level(serial_test_pin_level),
		.pin_input_mode(pin_input_mode),
		.thermal_event(thermal_event),
		.adc_buffer_on(adc_buffer_on),
		.supply_stayed_ok(supply_stayed_ok),
		.low_voltage_flag_en(low_voltage_flag_en),
		.low_voltage_flag_en_wr(low_voltage_flag_en_wr),
		.driver_reenable_wr(driver_reenable_wr),
		.line_short_event(line_short_event),
		.serial_test_short_event(serial_test_short_event),
		.wake_short_event(wake_short_event),
		.hv_busy_ff(hv_busy_ff),
		.hv_error_ff(hv_error_ff),
		.hv_data_register_ff(hv_data_register_ff),
		.hv_monitor_status_ff(hv_monitor_status_ff),
		.driver_reenable_ff(driver_reenable_ff)
	);
	initial forever #25 clk_sys = ~clk_sys;
	////////////////////////////////////////
	function automatic logic [31:0] nx(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : nx
	// Pin bits masked when input mode is off: level then undefined
	function automatic logic [7:0] ex();
		return {wake_pin_level, ms[6], serial_test_pin_level, adc_buffer_on,
			ms[3] & low_voltage_flag_en, ms[2:0]} & mk;
	endfunction : ex
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		cmp_count++;
		if (s !== e) begin
			mismatches++;
			$display("BAD %0t got %h want %h", $time, s, e);
		end
	endtask : chk
	task automatic give_verdict();
		$display("mismatches %0d compares %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : give_verdict
	task automatic pls(input logic [4:0] v);
		{thermal_event, line_short_event, serial_test_short_event, wake_short_event,
			driver_reenable_wr} = v;
	endtask : pls
	// Second start while busy must be ignored
	task automatic rd(input logic [2:0] s);
		int n;
		n = 0;
		cmd_sel = s;
		cmd_start = 1;
		@(negedge clk_sys);
		cmd_sel = 3'h2;
		@(negedge clk_sys);
		cmd_start = 0;
		while (hv_busy_ff !== 1'b0 && n < 400) begin
			@(negedge clk_sys);
			n++;
		end
		chk({7'h0, hv_busy_ff}, 8'h00);
		chk(8'(n), 8'(hvm_pkg::BUSY_CYCLES - 1));
		cmd_sel = 3'h1;
	endtask : rd
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 8000) begin
			mismatches++;
			give_verdict();
		end
	end
	initial begin
		repeat (11) @(negedge clk_sys);
		chk(hv_monitor_status_ff, 8'h00);
		@(negedge clk_sys);
		rst_n = 1;
		repeat (3) @(negedge clk_sys);
		chk(hv_monitor_status_ff, 8'h00);
		low_voltage_flag_en = 1;
		for (int i = 0; i < 24; i++) begin
			lf = nx(lf);
			{wake_pin_level, serial_test_pin_level, pin_input_mode, adc_buffer_on} = lf[3:0];
			mk = pin_input_mode ? 8'hFF : 8'h5F;
			ev = lf[8:4] & {5{lf[9]}};
			if (ev[0]) ms = ms & 8'h08;
			ms = ms | {1'b0, ev[4], 3'h0, ev[3:1]};
			pls(ev);
			@(negedge clk_sys);
			chk({7'h0, driver_reenable_ff}, {7'h0, ev[0]});
			pls(5'h00);
			rd(3'h1);
			chk(hv_data_register_ff & mk, ex());
			chk(hv_monitor_status_ff & mk, ex());
			chk({6'h0, hv_error_ff, driver_reenable_ff}, 8'h00);
		end
		pv = hv_data_register_ff;
		rd(3'h4);
		chk({7'h0, hv_error_ff}, 8'h01);
		chk(hv_data_register_ff, pv);
		for (int j = 0; j < 2; j++) begin
			low_voltage_flag_en = j[0];
			low_voltage_flag_en_wr = 1;
			@(negedge clk_sys);
			low_voltage_flag_en_wr = 0;
			low_voltage_flag_en = 1;
			if (j == 1) ms[3] = 1'b0;
			repeat (3) @(negedge clk_sys);
			chk(hv_monitor_status_ff & mk, ex());
		end
		// Second reset with the supply strap low: RAM reported corrupt
		supply_stayed_ok = 0;
		rst_n = 0;
		@(negedge clk_sys);
		chk(hv_monitor_status_ff, 8'h00);
		chk({6'h0, hv_busy_ff, driver_reenable_ff}, 8'h00);
		rst_n = 1;
		ms = 8'h00;
		repeat (3) @(negedge clk_sys);
		chk(hv_monitor_status_ff & mk, ex());
		rd(3'h1);
		chk(hv_data_register_ff & mk, ex());
		chk({7'h0, hv_error_ff}, 8'h00);
		give_verdict();
	end
endmodule : tb
